// ===== src/opdec_regs.svh
`ifndef OPDEC_REGS_SVH
`define OPDEC_REGS_SVH

// Bytes of the fetch window offered per instruction slot
`define FETCH_BYTES 12
// Bytes in a far pointer view
`define FAR_PTR_BYTES 6

// ModR/M field positions
`define MODRM_MOD_MSB 7
`define MODRM_MOD_LSB 6
`define MODRM_REG_MSB 5
`define MODRM_REG_LSB 3
`define MODRM_RM_MSB 2
`define MODRM_RM_LSB 0

// ModR/M field values
`define MOD_REGISTER 2'b11
`define MOD_DISP0 2'b00
`define MOD_DISP8 2'b01
`define MOD_DISPW 2'b10
`define RM_SIB 3'b100
`define RM_DISP32_ONLY 3'b101
`define RM_DISP16_ONLY 3'b110
`define SIB_BASE_NONE 3'b101
`define GRP_ADD 3'b000
`define GRP_ADC 3'b010

// Opcode bytes
`define OPC_ASCII_ADJ_ADD 8'h37
`define OPC_ASCII_ADJ_SUB 8'h3F
`define OPC_ASCII_ADJ_MUL 8'hD4
`define OPC_ASCII_ADJ_DIV 8'hD5
`define OPC_ASCII_ADJ_BASE 8'h0A
`define OPC_ADC_RM8_R8 8'h10
`define OPC_ADC_RMW_RW 8'h11
`define OPC_ADC_R8_RM8 8'h12
`define OPC_ADC_RW_RMW 8'h13
`define OPC_ADC_ACC8_IMM 8'h14
`define OPC_ADC_ACCW_IMM 8'h15
`define OPC_ADD_RM8_R8 8'h00
`define OPC_ADD_RMW_RW 8'h01
`define OPC_ADD_R8_RM8 8'h02
`define OPC_ADD_RW_RMW 8'h03
`define OPC_ADD_ACC8_IMM 8'h04
`define OPC_ADD_ACCW_IMM 8'h05
`define OPC_GRP_BYTE_IMMEDIATE 8'h80
`define OPC_GRP_IMMW 8'h81
`define OPC_GRP_IMMSX 8'h83

`endif

// ===== src/opdec_pkg.sv
`default_nettype none

package opdec_pkg;
`include "opdec_regs.svh"

  // Decode class of one instruction
  typedef enum logic [1:0] {CLS_NONE, CLS_SHORT, CLS_LONG, CLS_VECTOR} decode_class_t;

  // Internal operation kinds
  typedef enum logic [2:0] {
    OP_ALU, OP_ALUX, OP_BRANCH, OP_FLOAT, OP_LIMM, OP_LOAD, OP_STORE, OP_MEU
  } op_kind_t;

  // Execution units
  typedef enum logic [2:0] {
    UNIT_INT_X, UNIT_INT_Y, UNIT_BRANCH, UNIT_ICU, UNIT_LOAD, UNIT_STORE, UNIT_FPU, UNIT_MEU
  } exec_unit_t;

  // Immediate size class
  typedef enum logic [1:0] {IMM_NONE, IMM_BYTE, IMM_WIDE} imm_kind_t;

  // One instruction offered by fetch, byte 0 in the low bits
  typedef struct packed {
    logic valid;
    logic opSize32;
    logic addrSize32;
    logic [`FETCH_BYTES*8-1:0] bytes;
  } fetch_slot_t;

  // Operand fields pulled from the instruction bytes
  typedef struct packed {
    logic memForm;
    logic [1:0] memoryFormField;
    logic [2:0] regField;
    logic [2:0] rmField;
    logic [2:0] firstVectorRegister;
    logic [2:0] secondVectorRegister;
    logic [2:0] byteRegisterOperand;
    logic [2:0] wideRegisterOperand;
    logic [31:0] disp;
    logic [2:0] dispBytes;
    logic [31:0] imm;
    logic [2:0] immBytes;
    logic [47:0] farPointer;
    logic [3:0] length;
  } operand_fields_t;

  // One internal operation with its unit
  typedef struct packed {
    logic valid;
    op_kind_t kind;
    exec_unit_t unit;
  } uop_t;

  // Opcode classification result
  typedef struct packed {
    logic known;
    decode_class_t cls;
    logic [1:0] uopCount;
    op_kind_t [2:0] kinds;
    logic hasModrm;
    imm_kind_t immKind;
  } class_info_t;

  // One decoded instruction as issued
  typedef struct packed {
    logic valid;
    logic invalid;
    logic [7:0] opcode;
    decode_class_t cls;
    logic [1:0] uopCount;
    uop_t [2:0] uops;
    operand_fields_t fields;
  } issue_t;

endpackage

`default_nettype wire

// ===== src/uop_router.sv
`timescale 1ns/1ps
`default_nettype none

// Steers one operation to its execution unit
module uop_router
  import opdec_pkg::*;
(
  // Operation in
  input wire op_kind_t kind,
  input wire logic preferY,
  // Unit out
  output exec_unit_t unit
);

  // Kind to unit mapping
  always_comb begin
    case (kind)
      OP_ALU: unit = preferY ? UNIT_INT_Y : UNIT_INT_X;
      OP_ALUX: unit = UNIT_INT_X;
      OP_BRANCH: unit = UNIT_BRANCH;
      OP_LIMM: unit = UNIT_ICU;
      OP_LOAD: unit = UNIT_LOAD;
      OP_STORE: unit = UNIT_STORE;
      OP_FLOAT: unit = UNIT_FPU;
      OP_MEU: unit = UNIT_MEU;
      default: unit = UNIT_INT_X;
    endcase
  end

endmodule // uop_router

`default_nettype wire

// ===== src/operand_extract.sv
`timescale 1ns/1ps
`default_nettype none

// Pulls ModR/M fields, displacement, immediate and length from the bytes
module operand_extract
  import opdec_pkg::*;
(
  // Instruction bytes and sizes
  input wire logic [`FETCH_BYTES*8-1:0] bytes,
  input wire logic opSize32,
  input wire logic addrSize32,
  // Format hints from the classifier
  input wire logic hasModrm,
  input wire imm_kind_t immKind,
  // Extracted fields
  output operand_fields_t fields
);

  // Raw little-endian gather of n bytes from pos, clipped to the window
  function automatic logic [47:0] gatherBytes(input logic [`FETCH_BYTES*8-1:0] b,
                                              input logic [3:0] pos, input logic [2:0] n);
    logic [47:0] acc;
    acc = 48'h0000_0000_0000;
    for (int i = 0; i < `FAR_PTR_BYTES; i++) begin
      if (i < int'(n) && int'(pos) + i < `FETCH_BYTES) begin
        acc[i*8 +: 8] = b[(int'(pos) + i)*8 +: 8];
      end
    end
    return acc;
  endfunction

  // Sign extension of a 1, 2 or 4 byte value to 32 bits
  function automatic logic [31:0] signExt(input logic [47:0] raw, input logic [2:0] n);
    case (n)
      3'd1: return {{24{raw[7]}}, raw[7:0]};
      3'd2: return {{16{raw[15]}}, raw[15:0]};
      default: return raw[31:0];
    endcase
  endfunction

  logic [7:0] modrm; // ModR/M byte, always right after the opcode
  logic [7:0] sib; // Scale-index-base byte
  logic [1:0] modBits; // Register or memory selector
  logic [2:0] rmBits; // Register or base selector
  logic sibPresent; // 32-bit addressing with SIB
  logic [3:0] dispPos; // First displacement byte
  logic [3:0] immPos; // First immediate byte

  // Field extraction
  always_comb begin
    modrm = bytes[15:8];
    sib = bytes[23:16];
    modBits = modrm[`MODRM_MOD_MSB:`MODRM_MOD_LSB];
    rmBits = modrm[`MODRM_RM_MSB:`MODRM_RM_LSB];
    fields = '0;
    fields.memoryFormField = modBits;
    fields.memForm = hasModrm && (modBits != `MOD_REGISTER);
    fields.regField = modrm[`MODRM_REG_MSB:`MODRM_REG_LSB];
    fields.rmField = rmBits;
    fields.firstVectorRegister = modrm[`MODRM_REG_MSB:`MODRM_REG_LSB];
    fields.secondVectorRegister = modrm[`MODRM_RM_MSB:`MODRM_RM_LSB];
    // Accumulator forms name the register by opcode alone, which is register 0
    fields.byteRegisterOperand = hasModrm ? modrm[`MODRM_REG_MSB:`MODRM_REG_LSB] : 3'b000;
    fields.wideRegisterOperand = hasModrm ? modrm[`MODRM_REG_MSB:`MODRM_REG_LSB] : 3'b000;
    sibPresent = fields.memForm && addrSize32 && (rmBits == `RM_SIB);
    // Displacement size by addressing mode
    if (!fields.memForm) begin
      fields.dispBytes = 3'd0;
    end else if (modBits == `MOD_DISP8) begin
      fields.dispBytes = 3'd1;
    end else if (modBits == `MOD_DISPW) begin
      fields.dispBytes = addrSize32 ? 3'd4 : 3'd2;
    end else if (addrSize32 && (rmBits == `RM_DISP32_ONLY ||
                 (sibPresent && sib[2:0] == `SIB_BASE_NONE))) begin
      fields.dispBytes = 3'd4;
    end else if (!addrSize32 && rmBits == `RM_DISP16_ONLY) begin
      fields.dispBytes = 3'd2;
    end else begin
      fields.dispBytes = 3'd0;
    end
    dispPos = hasModrm ? (sibPresent ? 4'd3 : 4'd2) : 4'd1;
    fields.disp = signExt(gatherBytes(bytes, dispPos, fields.dispBytes), fields.dispBytes);
    immPos = 4'(dispPos + {1'b0, fields.dispBytes});
    // Immediate size follows operand size for wide forms
    case (immKind)
      IMM_BYTE: fields.immBytes = 3'd1;
      IMM_WIDE: fields.immBytes = opSize32 ? 3'd4 : 3'd2;
      default: fields.immBytes = 3'd0;
    endcase
    fields.imm = signExt(gatherBytes(bytes, immPos, fields.immBytes), fields.immBytes);
    // Offset plus selector view for far pointer forms
    fields.farPointer = gatherBytes(bytes, immPos, 3'(`FAR_PTR_BYTES));
    fields.length = 4'(immPos + {1'b0, fields.immBytes});
  end

endmodule // operand_extract

`default_nettype wire

// ===== src/x86_integer_opcode_decoder.sv
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - Per cycle: two short, one long, one vector; the decoder takes such a group only every other cycle
// - ModR/M bits 7:6 = 11 register, else memory
// - First vector register from ModR/M bits 5:3
// - Second vector register from ModR/M bits 2:0
// - General register from opcode or bits 5:3
// - Extract displacements, far pointers, sized immediates
// - Generic ALU either pipe, restricted only X
// - Route each operation kind to its unit
// - All add-with-carry forms decode as vector
// - Group opcodes reg 010 are add-with-carry immediate
// - Register add: short, one operation
// - Memory-destination add: long, load, ALU, store
// - Memory-source add: short, load then ALU
// - Group opcodes reg 000 are add immediate
module x86_integer_opcode_decoder
  import opdec_pkg::*;
#(
  parameter int SLOTS = 2,
  parameter int UOPS = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fetch side
  input wire fetch_slot_t [SLOTS-1:0] fetchSlots,
  output logic [1:0] takenCount,
  // Execution side
  input wire logic execReady,
  output logic issueValid,
  output issue_t [SLOTS-1:0] issue
);

  // Builds a class record from its parts
  function automatic class_info_t mkClass(input decode_class_t cls, input logic [1:0] cnt,
                                          input op_kind_t k0, input op_kind_t k1,
                                          input op_kind_t k2, input logic modrmUsed,
                                          input imm_kind_t imm);
    class_info_t ci;
    ci.known = 1'b1;
    ci.cls = cls;
    ci.uopCount = cnt;
    ci.kinds[0] = k0;
    ci.kinds[1] = k1;
    ci.kinds[2] = k2;
    ci.hasModrm = modrmUsed;
    ci.immKind = imm;
    return ci;
  endfunction

  // Register form in one operation, memory destination in three
  function automatic class_info_t destForm(input logic mem, input op_kind_t alu,
                                           input imm_kind_t imm);
    if (mem) begin
      return mkClass(CLS_LONG, 2'd3, OP_LOAD, alu, OP_STORE, 1'b1, imm);
    end
    return mkClass(CLS_SHORT, 2'd1, alu, OP_ALU, OP_ALU, 1'b1, imm);
  endfunction

  // Register form in one operation, memory source in two
  function automatic class_info_t srcForm(input logic mem, input op_kind_t alu);
    if (mem) begin
      return mkClass(CLS_SHORT, 2'd2, OP_LOAD, alu, OP_ALU, 1'b1, IMM_NONE);
    end
    return mkClass(CLS_SHORT, 2'd1, alu, OP_ALU, OP_ALU, 1'b1, IMM_NONE);
  endfunction

  // Opcode classification for one slot
  function automatic class_info_t classify(input logic [7:0] opc, input logic [7:0] nxt);
    class_info_t ci;
    logic mem;
    logic [2:0] grp;
    mem = (nxt[`MODRM_MOD_MSB:`MODRM_MOD_LSB] != `MOD_REGISTER);
    grp = nxt[`MODRM_REG_MSB:`MODRM_REG_LSB];
    // Unknown unless matched below; passed alone for the exception path
    ci = mkClass(CLS_VECTOR, 2'd0, OP_ALU, OP_ALU, OP_ALU, 1'b0, IMM_NONE);
    ci.known = 1'b0;
    case (opc)
      // ASCII adjust, microcoded
      `OPC_ASCII_ADJ_ADD, `OPC_ASCII_ADJ_SUB: begin
        ci = mkClass(CLS_VECTOR, 2'd0, OP_ALU, OP_ALU, OP_ALU, 1'b0, IMM_NONE);
      end
      // Adjust with base byte, only the decimal base is listed
      `OPC_ASCII_ADJ_MUL, `OPC_ASCII_ADJ_DIV: begin
        if (nxt == `OPC_ASCII_ADJ_BASE) begin
          ci = mkClass(CLS_VECTOR, 2'd0, OP_ALU, OP_ALU, OP_ALU, 1'b0, IMM_BYTE);
        end
      end
      // Add with carry, register and memory forms
      `OPC_ADC_RM8_R8, `OPC_ADC_RMW_RW, `OPC_ADC_R8_RM8, `OPC_ADC_RW_RMW: begin
        ci = mkClass(CLS_VECTOR, 2'd0, OP_ALU, OP_ALU, OP_ALU, 1'b1, IMM_NONE);
      end
      // Add with carry, accumulator forms
      `OPC_ADC_ACC8_IMM: begin
        ci = mkClass(CLS_VECTOR, 2'd0, OP_ALU, OP_ALU, OP_ALU, 1'b0, IMM_BYTE);
      end
      `OPC_ADC_ACCW_IMM: begin
        ci = mkClass(CLS_VECTOR, 2'd0, OP_ALU, OP_ALU, OP_ALU, 1'b0, IMM_WIDE);
      end
      // Add, destination is the ModR/M operand
      `OPC_ADD_RM8_R8: begin
        ci = destForm(mem, OP_ALUX, IMM_NONE);
      end
      `OPC_ADD_RMW_RW: begin
        ci = destForm(mem, OP_ALU, IMM_NONE);
      end
      // Add, destination is the register operand
      `OPC_ADD_R8_RM8: begin
        ci = srcForm(mem, OP_ALUX);
      end
      `OPC_ADD_RW_RMW: begin
        ci = srcForm(mem, OP_ALU);
      end
      // Add to accumulator
      `OPC_ADD_ACC8_IMM: begin
        ci = mkClass(CLS_SHORT, 2'd1, OP_ALUX, OP_ALU, OP_ALU, 1'b0, IMM_BYTE);
      end
      `OPC_ADD_ACCW_IMM: begin
        ci = mkClass(CLS_SHORT, 2'd1, OP_ALU, OP_ALU, OP_ALU, 1'b0, IMM_WIDE);
      end
      // Immediate group, byte immediate
      `OPC_GRP_BYTE_IMMEDIATE, `OPC_GRP_IMMSX: begin
        if (grp == `GRP_ADC) begin
          ci = mkClass(CLS_VECTOR, 2'd0, OP_ALU, OP_ALU, OP_ALU, 1'b1, IMM_BYTE);
        end else if (grp == `GRP_ADD) begin
          ci = destForm(mem, OP_ALUX, IMM_BYTE);
        end
      end
      // Immediate group, operand-size immediate
      `OPC_GRP_IMMW: begin
        if (grp == `GRP_ADC) begin
          ci = mkClass(CLS_VECTOR, 2'd0, OP_ALU, OP_ALU, OP_ALU, 1'b1, IMM_WIDE);
        end else if (grp == `GRP_ADD) begin
          ci = destForm(mem, OP_ALU, IMM_WIDE);
        end
      end
      default: begin
        ci.known = 1'b0;
      end
    endcase
    return ci;
  endfunction

  // Registered state
  logic gapCycle; // Fetch realigns for one cycle after a take
  logic pipeToggle; // Alternates generic ALU work between pipes
  logic [1:0] next_takenCount;
  logic next_issueValid;
  issue_t [SLOTS-1:0] next_issue;
  logic next_gapCycle;
  logic next_pipeToggle;

  // Per-slot decode results
  class_info_t [SLOTS-1:0] info;
  operand_fields_t [SLOTS-1:0] fields;
  exec_unit_t [SLOTS-1:0][UOPS-1:0] units;
  issue_t [SLOTS-1:0] cand;

  // Decoding lanes, one per fetch slot
  for (genvar s = 0; s < SLOTS; s++) begin : gLane
    // Opcode class from the first two bytes
    always_comb begin
      info[s] = classify(fetchSlots[s].bytes[7:0], fetchSlots[s].bytes[15:8]);
    end

    // Operand fields and instruction length
    operand_extract uExtract (
      .bytes(fetchSlots[s].bytes),
      .opSize32(fetchSlots[s].opSize32),
      .addrSize32(fetchSlots[s].addrSize32),
      .hasModrm(info[s].hasModrm),
      .immKind(info[s].immKind),
      .fields(fields[s])
    );

    // Unit steering, neighbouring operations start on opposite pipes
    for (genvar u = 0; u < UOPS; u++) begin : gUop
      uop_router uRoute (
        .kind(info[s].kinds[u]),
        .preferY(pipeToggle ^ s[0] ^ u[0]),
        .unit(units[s][u])
      );
    end

    // Candidate issue record
    always_comb begin
      cand[s] = '0;
      cand[s].valid = fetchSlots[s].valid;
      cand[s].invalid = !info[s].known;
      cand[s].opcode = fetchSlots[s].bytes[7:0];
      cand[s].cls = info[s].cls;
      cand[s].uopCount = info[s].uopCount;
      cand[s].fields = fields[s];
      for (int u = 0; u < UOPS; u++) begin
        cand[s].uops[u].valid = (u < int'(info[s].uopCount));
        cand[s].uops[u].kind = info[s].kinds[u];
        cand[s].uops[u].unit = units[s][u];
      end
    end
  end

  logic canTake; // Slot 0 is taken this cycle
  logic takePair; // Slot 1 is taken along with slot 0

  // Acceptance and issue next-state
  always_comb begin
    next_issueValid = issueValid;
    next_issue = issue;
    next_takenCount = 2'd0;
    next_gapCycle = 1'b0;
    next_pipeToggle = pipeToggle;
    // Downstream drains the held group
    if (issueValid && execReady) begin
      next_issueValid = 1'b0;
    end
    canTake = !gapCycle && fetchSlots[0].valid && (!issueValid || execReady);
    // Only two short instructions may pair; long or vector goes alone
    takePair = fetchSlots[1].valid && cand[0].cls == CLS_SHORT &&
               cand[1].cls == CLS_SHORT;
    if (canTake) begin
      next_issueValid = 1'b1;
      next_issue = '0;
      next_issue[0] = cand[0];
      // Second slot only when paired
      if (takePair) begin
        next_issue[1] = cand[1];
        next_takenCount = 2'd2;
      end else begin
        next_takenCount = 2'd1;
      end
      next_gapCycle = 1'b1;
      next_pipeToggle = !pipeToggle;
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      takenCount <= 2'd0;
      issueValid <= 1'b0;
      issue <= '0;
      gapCycle <= 1'b0;
      pipeToggle <= 1'b0;
    end else begin
      takenCount <= next_takenCount;
      issueValid <= next_issueValid;
      issue <= next_issue;
      gapCycle <= next_gapCycle;
      pipeToggle <= next_pipeToggle;
    end
  end

endmodule // x86_integer_opcode_decoder

`default_nettype wire

// ===== verification/opdec_chk.sv
`timescale 1ns/1ps
`default_nettype none

// Watches decoder ports for pairing, class and routing relations
module opdec_chk
  import opdec_pkg::*;
#(
  parameter int SLOTS = 2,
  parameter int UOPS = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fetch side
  input wire fetch_slot_t [SLOTS-1:0] fetchSlots,
  input wire logic [1:0] takenCount,
  // Execution side
  input wire logic execReady,
  input wire logic issueValid,
  input wire issue_t [SLOTS-1:0] issue
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // A group was just taken from fetch
  sequence s_take;
    takenCount != 2'h0;
  endsequence
  // Oldest slot holds a supported instruction
  sequence s_good0;
    issueValid && issue[0].valid && !issue[0].invalid;
  endsequence

  property p_answer;
    s_take |-> issueValid;
  endproperty
  a_answer: assert property (p_answer) else $error("take without issue");
  property p_gap;
    s_take |=> takenCount == 2'h0;
  endproperty
  a_gap: assert property (p_gap) else $error("take on back to back edges");
  property p_pair;
    takenCount == 2'h2 |-> issue[1].valid && issue[0].cls == CLS_SHORT && issue[1].cls == CLS_SHORT;
  endproperty
  a_pair: assert property (p_pair) else $error("pair not both short");
  property p_alone;
    takenCount == 2'h1 |-> !issue[1].valid;
  endproperty
  a_alone: assert property (p_alone) else $error("second slot set on single take");
  property p_long_mem;
    s_good0 ##0 issue[0].cls == CLS_LONG |->
      issue[0].fields.memForm && issue[0].fields.memoryFormField != 2'h3;
  endproperty
  a_long_mem: assert property (p_long_mem) else $error("long without memory form");
  property p_regs;
    s_good0 ##0 issue[0].opcode <= 8'h03 |->
      issue[0].fields.firstVectorRegister == issue[0].fields.regField &&
      issue[0].fields.secondVectorRegister == issue[0].fields.rmField;
  endproperty
  a_regs: assert property (p_regs) else $error("register field mismatch");
  property p_alux;
    s_good0 |-> (issue[0].uops[0].kind != OP_ALUX || issue[0].uops[0].unit == UNIT_INT_X) &&
      (issue[0].uops[1].kind != OP_ALUX || issue[0].uops[1].unit == UNIT_INT_X);
  endproperty
  a_alux: assert property (p_alux) else $error("restricted op off pipe X");
  property p_route;
    s_good0 ##0 issue[0].cls == CLS_LONG |-> issue[0].uops[0].unit == UNIT_LOAD &&
      issue[0].uops[2].unit == UNIT_STORE && issue[0].uops[1].unit inside {UNIT_INT_X, UNIT_INT_Y};
  endproperty
  a_route: assert property (p_route) else $error("long group misrouted");
  property p_adc;
    issueValid && issue[0].valid && issue[0].opcode inside {[8'h10:8'h15]} |->
      issue[0].cls == CLS_VECTOR && !issue[0].invalid && issue[0].uopCount == 2'h0;
  endproperty
  a_adc: assert property (p_adc) else $error("carry add not vector");
  property p_hold;
    issueValid && !execReady |=> issueValid && $stable(issue);
  endproperty
  a_hold: assert property (p_hold) else $error("issue group dropped while stalled");
endmodule // opdec_chk

`default_nettype wire

// ===== verification/exec_sink.sv
`timescale 1ns/1ps
`default_nettype none

// Execution side: always ready, or ready one cycle in three
module exec_sink (
  // Clock and mode
  input wire logic sys_clk,
  input wire logic slowMode,
  // Consume strobe
  output logic execReady
);
  logic [1:0] phase; // Stall pattern position
  initial begin
    phase = 2'h0;
    execReady = 1'b1;
  end
  // Changes away from the sampling edge
  always @(negedge sys_clk) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    execReady <= !slowMode || (phase == 2'h0);
  end
endmodule // exec_sink

`default_nettype wire

// ===== verification/x86_integer_opcode_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none

// Feeds instruction pairs and compares each decode with a reference
module x86_integer_opcode_decoder_test;
  import opdec_pkg::*;
  // Expected decode of one instruction
  typedef struct packed {
    logic inv; logic hasM; logic ops; decode_class_t cls; logic [1:0] n; op_kind_t [2:0] k;
    logic [3:0] len; logic [31:0] disp; logic [2:0] dispB; logic [31:0] imm; logic [2:0] immB;
  } exp_t;
  localparam logic [7:0] OPS [21] = '{8'h37, 8'h3F, 8'hD4, 8'hD5, 8'h10, 8'h11, 8'h12,
    8'h13, 8'h14, 8'h15, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h80, 8'h81, 8'h83,
    8'h20, 8'hF4};
  logic sys_clk = 1'b0; // Core clock
  logic rst_n; // Reset, active low
  logic slowMode; // Stall selector for the sink
  fetch_slot_t [1:0] fetchSlots;
  logic [1:0] takenCount;
  logic execReady;
  logic issueValid;
  issue_t [1:0] issue;
  logic sz32 = 1'b1; // Operand and address size of both slots
  logic pipeTog = 1'b0; // Pipe choice expected for the next take
  int seed = 32'h274a_71de;
  int errTotal = 0;
  int nTests = 0;
  logic [95:0] q [$]; // Instructions waiting for fetch

  always #12.5 sys_clk = ~sys_clk;

  x86_integer_opcode_decoder u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .fetchSlots(fetchSlots),
    .takenCount(takenCount), .execReady(execReady), .issueValid(issueValid), .issue(issue));
  exec_sink u_sink (.sys_clk(sys_clk), .slowMode(slowMode), .execReady(execReady));

  // Verdict and end of run
  task automatic finishTest();
    if (errTotal == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Compares one value with its expectation
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      errTotal++;
    end
  endtask

  // Sign extension of a 1, 2 or 4 byte field
  function automatic logic [31:0] sx(input logic [31:0] v, input logic [2:0] n);
    return n == 3'h1 ? {{24{v[7]}}, v[7:0]} : n == 3'h2 ? {{16{v[15]}}, v[15:0]} :
      n == 3'h4 ? v : 32'h0000_0000;
  endfunction

  // Reference decode from the opcode table
  function automatic exp_t expectOf(input logic [95:0] b);
    exp_t e;
    logic [7:0] op;
    logic [7:0] m;
    logic mem;
    logic [95:0] sh;
    op_kind_t alu;
    op = b[7:0];
    m = b[15:8];
    mem = m[7:6] != 2'h3;
    e = '0;
    e.inv = 1'b1;
    e.cls = CLS_VECTOR;
    e.len = 4'h1;
    e.hasM = op inside {8'h00, 8'h01, 8'h02, 8'h03, [8'h10:8'h13], 8'h80, 8'h81, 8'h83};
    e.immB = op inside {8'h04, 8'h14, 8'h80, 8'h83} ? 3'h1 :
      op inside {8'h05, 8'h15, 8'h81} ? (sz32 ? 3'h4 : 3'h2) : 3'h0;
    e.dispB = (!e.hasM || !mem) ? 3'h0 : m[7:6] == 2'h1 ? 3'h1 :
      m[7:6] == 2'h2 ? (sz32 ? 3'h4 : 3'h2) : 3'h0;
    e.disp = sx(b[47:16], e.dispB);
    sh = b >> ((1 + e.hasM + e.dispB) * 8);
    e.imm = sx(sh[31:0], e.immB);
    alu = (op[0] && op != 8'h83) ? OP_ALU : OP_ALUX;
    if (op inside {8'h37, 8'h3F, [8'h10:8'h15]} || (op inside {8'hD4, 8'hD5} && m == 8'h0A) ||
        (op inside {8'h80, 8'h81, 8'h83} && m[5:3] == 3'h2)) begin
      e.inv = 1'b0;
      e.ops = !(op inside {8'hD4, 8'hD5});
      e.len = e.ops ? 4'(1 + e.hasM + e.dispB + e.immB) : 4'h2;
    end else if (op <= 8'h05 || (op inside {8'h80, 8'h81, 8'h83} && m[5:3] == 3'h0)) begin
      e.inv = 1'b0;
      e.ops = 1'b1;
      e.len = 4'(1 + e.hasM + e.dispB + e.immB);
      e.cls = CLS_SHORT;
      if (!mem || !e.hasM) begin
        e.n = 2'h1;
        e.k[0] = alu;
      end else begin
        e.n = op inside {8'h02, 8'h03} ? 2'h2 : 2'h3;
        e.cls = e.n == 2'h2 ? CLS_SHORT : CLS_LONG;
        e.k[0] = OP_LOAD;
        e.k[1] = alu;
        e.k[2] = OP_STORE;
      end
    end
    return e;
  endfunction

  // Unit an operation kind must reach; y is the expected pipe choice
  function automatic exec_unit_t unitOf(input op_kind_t k, input logic y);
    case (k)
      OP_LOAD: return UNIT_LOAD;
      OP_STORE: return UNIT_STORE;
      OP_ALU: return y ? UNIT_INT_Y : UNIT_INT_X;
      default: return UNIT_INT_X;
    endcase
  endfunction

  // Compares one issued slot with the reference
  task automatic checkOne(input int s, input logic [95:0] b);
    exp_t e;
    issue_t t;
    logic [95:0] sh;
    e = expectOf(b);
    t = issue[s];
    sh = b >> ((1 + e.hasM + e.dispB) * 8);
    check("opcode", t.opcode, b[7:0]);
    check("invalid", t.invalid, e.inv);
    check("class", t.cls, e.cls);
    check("uopCount", t.uopCount, e.n);
    check("length", t.fields.length, e.len);
    for (int i = 0; i < e.n; i++) begin
      check("kind", t.uops[i].kind, e.k[i]);
      check("unit", t.uops[i].unit, unitOf(e.k[i], pipeTog ^ s[0] ^ i[0]));
    end
    for (int i = 0; i < 3; i++) begin
      check("uopValid", t.uops[i].valid, i < int'(e.n));
    end
    check("memForm", t.fields.memForm, e.hasM && !e.inv && b[15:14] != 2'h3);
    if (!e.inv) begin
      check("farPtrHi", t.fields.farPointer[47:16], sh[47:16]);
      check("farPtrLo", t.fields.farPointer[15:0], sh[15:0]);
    end
    if (e.hasM) begin
      check("vectorRegs", {t.fields.firstVectorRegister, t.fields.secondVectorRegister}, b[13:8]);
    end
    if (b[7:0] <= 8'h05) begin
      check("regOperand", b[0] ? t.fields.wideRegisterOperand : t.fields.byteRegisterOperand,
        e.hasM ? b[13:11] : 3'h0);
    end
    if (e.ops) begin
      check("disp", t.fields.disp, e.disp);
      check("dispBytes", t.fields.dispBytes, e.dispB);
      check("imm", t.fields.imm, e.imm);
      check("immBytes", t.fields.immBytes, e.immB);
    end
  endtask

  // Random instruction drawn from the opcode table
  function automatic logic [95:0] randInstr();
    logic [95:0] b;
    b = {$random(seed), $random(seed), $random(seed)};
    b[7:0] = OPS[$unsigned($random(seed)) % 21];
    if (b[7:0] inside {8'h80, 8'h81, 8'h83} && b[16]) b[13:11] = {1'b0, b[17], 1'b0};
    if (b[15:14] != 2'h3) b[10] = 1'b0;
    if (b[7:0] inside {8'hD4, 8'hD5} && b[18]) b[15:8] = 8'h0A;
    return b;
  endfunction

  // Offers queued instructions two at a time and checks every take
  task automatic runQueue();
    int w;
    logic [1:0] expTaken;
    while (q.size() > 0) begin
      fetchSlots[0] = {1'b1, sz32, sz32, q[0]};
      fetchSlots[1] = (q.size() > 1) ? {1'b1, sz32, sz32, q[1]} : '0;
      w = 0;
      do begin
        @(negedge sys_clk);
        w++;
      end while (takenCount === 2'h0 && w < 40);
      if (w >= 40) begin
        errTotal++;
        finishTest();
      end
      expTaken = (q.size() > 1 && expectOf(q[0]).cls == CLS_SHORT && !expectOf(q[0]).inv &&
        expectOf(q[1]).cls == CLS_SHORT && !expectOf(q[1]).inv) ? 2'h2 : 2'h1;
      check("takenCount", takenCount, expTaken);
      checkOne(0, q.pop_front());
      if (expTaken == 2'h2) checkOne(1, q.pop_front());
      else check("slot1Valid", issue[1].valid, 1'b0);
      pipeTog = !pipeTog;
    end
    fetchSlots = '0;
    @(negedge sys_clk);
  endtask

  initial begin
    rst_n = 1'b0;
    slowMode = 1'b0;
    fetchSlots = '0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    q = '{96'h0504_C800, 96'h0000_0001, 96'h0A_D4, 96'h07_D5, 96'h7F_C383, 96'h1234_5678_9A81,
      96'h0033_D580, 96'h0055_1083, 96'h42_02, 96'h47_11, 96'hF0_14, 96'h00_20};
    runQueue();
    repeat (200) q.push_back(randInstr());
    runQueue();
    slowMode = 1'b1;
    repeat (200) q.push_back(randInstr());
    runQueue();
    // Reset in mid-run clears the outputs
    rst_n = 1'b0;
    pipeTog = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    check("resetTaken", takenCount, 2'h0);
    check("resetValid", issueValid, 1'b0);
    slowMode = 1'b0;
    sz32 = 1'b0;
    repeat (100) q.push_back(randInstr());
    runQueue();
    finishTest();
  end
endmodule // x86_integer_opcode_decoder_test

bind x86_integer_opcode_decoder opdec_chk #(.SLOTS(SLOTS), .UOPS(UOPS)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .fetchSlots(fetchSlots), .takenCount(takenCount),
  .execReady(execReady), .issueValid(issueValid), .issue(issue));

`default_nettype wire
